/* hdl/sensor_serial_map.svh */
// Purpose: offsets, field positions, defaults and timing counts
// Assumes: 40 MHz system clock on both ends
// Notes: definitions only
`ifndef SENSOR_SERIAL_MAP_SVH
`define SENSOR_SERIAL_MAP_SVH

// ********************************************
// serial control link
// ********************************************
`define SLAVE_ADDR7 7'h10
`define SLAVE_ADDR_WRITE 8'h20
`define SLAVE_ADDR_READ 8'h21
`define REG_COUNT 128
`define IDX_AUTO_INC_BIT 7
`define PRIMARY_SETUP_REGISTER_INDEX 7'h10
`define PRIMARY_SETUP_REGISTER_DEFAULT 8'h01
`define PRIMARY_SETUP_REGISTER_LOW_POWER_BIT 0
`define PRIMARY_SETUP_REGISTER_SOFT_RESET_BIT 2
`define REG_DEFAULT 8'h00

// ********************************************
// nibble bus patterns
// ********************************************
`define NIBBLE_IDLE 5'h1F
`define NIBBLE_START_A 5'h09
`define NIBBLE_START_B 5'h06

// ********************************************
// timing
// ********************************************
`define SYS_CLK_PERIOD_NS 25
`define SCL_MIN_PERIOD_NS 10000
`define SCL_QUARTER_CYCLES ((`SCL_MIN_PERIOD_NS + 4 * `SYS_CLK_PERIOD_NS - 1) / (4 * `SYS_CLK_PERIOD_NS))

// ********************************************
// controller registers (wishbone byte offsets)
// ********************************************
`define HOST_CMD_OFFSET 4'h0
`define HOST_DATA_OFFSET 4'h4
`define HOST_STATUS_OFFSET 4'h8
`define CMD_GO_BIT 0
`define CMD_READ_BIT 1
`define CMD_NODATA_BIT 2
`define CMD_SETIDX_BIT 3
`define DATA_TX_LSB 0
`define DATA_INDEX_LSB 8
`define STAT_BUSY_BIT 0
`define STAT_NACK_BIT 1
`define STAT_RXDATA_LSB 8
`define STAT_RXINDEX_LSB 16

`endif

/* hdl/sensor_serial_pkg.sv */
// Purpose: shared types of the serial control link
// Assumes: nothing
// Notes: constants live in sensor_serial_map.svh
package sensor_serial_pkg;

  // device link states
  typedef enum logic [3:0] {
    DEV_IDLE = 4'h0,
    DEV_ADDR = 4'h1,
    DEV_ADDR_ACK = 4'h2,
    DEV_INDEX = 4'h3,
    DEV_INDEX_ACK = 4'h4,
    DEV_WDATA = 4'h5,
    DEV_WDATA_ACK = 4'h6,
    DEV_RDATA = 4'h7,
    DEV_RACK = 4'h8
  } dev_state_type;

  // controller message steps
  typedef enum logic [2:0] {
    STEP_START = 3'h0,
    STEP_ADDR_WR = 3'h1,
    STEP_ADDR_RD = 3'h2,
    STEP_INDEX = 3'h3,
    STEP_DATA = 3'h4,
    STEP_RECV_ACK = 3'h5,
    STEP_RECV_NACK = 3'h6,
    STEP_STOP = 3'h7
  } host_step_type;

  // wake-up sequence
  typedef enum logic [1:0] {
    WAKE_NONE = 2'h0,
    WAKE_ARMED = 2'h1,
    WAKE_FRAME = 2'h2
  } wake_type;

endpackage

/* hdl/sensor_serial_if.sv */
// Purpose: two-wire link between controller and sensor
// Assumes: both ends drive sda open-drain, pulled up
// Notes: scl is driven only by the controller
`timescale 1ns/100ps
`default_nettype none
interface sensor_serial_if;
  logic scl;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic sdaLine;

  // wired-and with pull-up
  assign sdaLine = !((hostSdaOe && !hostSdaOut) ||
                     (devSdaOe && !devSdaOut));

  modport device (
    input scl,
    input sdaLine,
    output devSdaOut,
    output devSdaOe
  );

  modport host (
    output scl,
    output hostSdaOut,
    output hostSdaOe,
    input sdaLine
  );
endinterface
`default_nettype wire

/* hdl/sensor_serial_device.sv */
// Purpose: sensor end: serial control slave, registers, power modes
// Assumes: scl and sda are asynchronous to sys_clk
// Notes: link pins sampled by sys_clk through two flip-flops
//
// Summary of operation
// - power-up in low power, nibble bus high
// - clearing setup bit 0 wakes; first frame invalid
// - low power drives ones; wake frame alternates 9/6
// - entering low power keeps all registers
// - suspend pin gates clock, powers analogue down
// - soft reset bit restores defaults, low power
// - master makes scl, at most 100 kHz
// - byte plus ack bit, sampled on rising scl
// - start/stop are sda edges while scl high
// - message starts with start, ends stop/restart
// - acknowledge own address, latch direction bit
// - addresses 32 write, 33 read
// - second write byte is index, msb auto-increment
// - auto-increment advances index once per data byte
// - acknowledge data byte, then store at index
// - read returns index, then register contents
// - receiver acknowledges each byte, except final read byte
// - with auto-increment, index ends one past last accessed location
// - only master ends message, incl. nack
// - master ends every read with nack
// - write without data only updates index
// - unknown index read: zero-data write, restart
`timescale 1ns/100ps
`default_nettype none
`include "sensor_serial_map.svh"
module sensor_serial_device
  import sensor_serial_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link to controller
  sensor_serial_if.device bus,
  // sensor core side
  input wire logic suspendPin,
  input wire logic frameStrobe,
  input wire logic [4:0] videoNibble,
  output logic [4:0] nibbleOut,
  output logic analogPowerDown,
  output logic clockGateOff,
  output logic lowPowerMode
);

  // ********************************************
  // pin synchronisers and edge detection
  // ********************************************
  logic [2:0] sclSync;
  logic [2:0] sdaSync;
  logic [1:0] suspendSync;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  // two stages, third only for edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
      suspendSync <= 2'h0;
    end else begin
      sclSync <= {sclSync[1:0], bus.scl};
      sdaSync <= {sdaSync[1:0], bus.sdaLine};
      suspendSync <= {suspendSync[0], suspendPin};
    end
  end

  // edges from second and third stages only
  assign sclRise = sclSync[1] && !sclSync[2];
  assign sclFall = !sclSync[1] && sclSync[2];
  assign startSeen = sclSync[1] && sclSync[2] &&
                     sdaSync[2] && !sdaSync[1];
  assign stopSeen = sclSync[1] && sclSync[2] &&
                    !sdaSync[2] && sdaSync[1];

  // ********************************************
  // register file
  // ********************************************
  logic [7:0] regs [0:`REG_COUNT-1];
  logic wrStrobe;
  logic [6:0] wrIndex;
  logic [7:0] wrData;
  logic softReset;

  assign softReset = wrStrobe && wrIndex == `PRIMARY_SETUP_REGISTER_INDEX &&
                     wrData[`PRIMARY_SETUP_REGISTER_SOFT_RESET_BIT];

  // one flop group per entry
  genvar g;
  generate
    for (g = 0; g < `REG_COUNT; g++) begin : gen_reg
      always_ff @(posedge sys_clk) begin
        if (rst || softReset) begin
          // defaults leave primary_setup_register in low power
          regs[g] <= (7'(g) == `PRIMARY_SETUP_REGISTER_INDEX) ? `PRIMARY_SETUP_REGISTER_DEFAULT
                                             : `REG_DEFAULT;
        end else if (wrStrobe && wrIndex == 7'(g)) begin
          regs[g] <= wrData;
        end
      end
    end
  endgenerate

  // ********************************************
  // link state machine
  // ********************************************
  dev_state_type state;
  logic [3:0] bitCnt;
  logic [7:0] rxShift;
  logic [7:0] txByte;
  logic readMode;
  logic [6:0] index;
  logic autoInc;
  logic masterNack;
  logic sdaOe;
  logic sdaOut;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= DEV_IDLE;
      bitCnt <= 4'h0;
      rxShift <= 8'h00;
      txByte <= 8'h00;
      readMode <= 1'b0;
      index <= 7'h00;
      autoInc <= 1'b0;
      masterNack <= 1'b0;
      sdaOe <= 1'b0;
      wrStrobe <= 1'b0;
      wrIndex <= 7'h00;
      wrData <= 8'h00;
    end else begin
      wrStrobe <= 1'b0;
      if (startSeen) begin
        // start or repeated start opens a message
        state <= DEV_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopSeen) begin
        state <= DEV_IDLE;
        sdaOe <= 1'b0;
      end else if (sclRise) begin
        // receive bits sampled on rising scl
        unique case (state)
          DEV_ADDR, DEV_INDEX, DEV_WDATA: begin
            rxShift <= {rxShift[6:0], sdaSync[1]};
            bitCnt <= bitCnt + 4'h1;
          end
          DEV_RACK: masterNack <= sdaSync[1];
          default: ;
        endcase
      end else if (sclFall) begin
        unique case (state)
          DEV_IDLE: ;
          DEV_ADDR: begin
            if (bitCnt == 4'h8) begin
              if (rxShift[7:1] == `SLAVE_ADDR7) begin
                sdaOe <= 1'b1;
                readMode <= rxShift[0];
                state <= DEV_ADDR_ACK;
              end else begin
                state <= DEV_IDLE;
              end
            end
          end
          DEV_ADDR_ACK: begin
            bitCnt <= 4'h0;
            if (readMode) begin
              // first read byte is the index
              txByte <= {autoInc, index};
              sdaOe <= !autoInc;
              bitCnt <= 4'h1;
              state <= DEV_RDATA;
            end else begin
              sdaOe <= 1'b0;
              state <= DEV_INDEX;
            end
          end
          DEV_INDEX: begin
            if (bitCnt == 4'h8) begin
              // index and auto-increment flag kept for later reads
              index <= rxShift[6:0];
              autoInc <= rxShift[`IDX_AUTO_INC_BIT];
              sdaOe <= 1'b1;
              state <= DEV_INDEX_ACK;
            end
          end
          DEV_INDEX_ACK, DEV_WDATA_ACK: begin
            sdaOe <= 1'b0;
            bitCnt <= 4'h0;
            state <= DEV_WDATA;
          end
          DEV_WDATA: begin
            if (bitCnt == 4'h8) begin
              // ack first, store behind it
              sdaOe <= 1'b1;
              wrStrobe <= 1'b1;
              wrIndex <= index;
              wrData <= rxShift;
              // advance only when flagged
              index <= index + {6'h00, autoInc};
              state <= DEV_WDATA_ACK;
            end
          end
          DEV_RDATA: begin
            if (bitCnt == 4'h8) begin
              sdaOe <= 1'b0; // master acknowledges
              state <= DEV_RACK;
            end else begin
              sdaOe <= !txByte[3'(4'h7 - bitCnt)];
              bitCnt <= bitCnt + 4'h1;
            end
          end
          DEV_RACK: begin
            if (masterNack) begin
              state <= DEV_IDLE; // master ends the read
              sdaOe <= 1'b0;
            end else begin
              // parallel load of addressed register
              txByte <= regs[index];
              sdaOe <= !regs[index][7];
              bitCnt <= 4'h1;
              index <= index + {6'h00, autoInc};
              state <= DEV_RDATA;
            end
          end
          default: state <= DEV_IDLE;
        endcase
      end
    end
  end

  // open-drain output only ever pulls low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  assign bus.devSdaOe = sdaOe;
  assign bus.devSdaOut = sdaOut;

  // ********************************************
  // power modes and nibble output
  // ********************************************
  wake_type wake;
  logic lowPower;
  logic lowPowerPrev;
  logic altPhase;

  assign lowPower = regs[`PRIMARY_SETUP_REGISTER_INDEX][`PRIMARY_SETUP_REGISTER_LOW_POWER_BIT];

  // start-up frame after leaving low power
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake <= WAKE_NONE;
      lowPowerPrev <= 1'b1;
      altPhase <= 1'b0;
    end else begin
      lowPowerPrev <= lowPower;
      altPhase <= !altPhase;
      if (lowPower) begin
        wake <= WAKE_NONE;
      end else if (lowPowerPrev) begin
        wake <= WAKE_ARMED;
      end else if (frameStrobe) begin
        unique case (wake)
          WAKE_ARMED: wake <= WAKE_FRAME;
          WAKE_FRAME: wake <= WAKE_NONE;
          default: wake <= WAKE_NONE;
        endcase
      end
    end
  end

  // registered pin outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nibbleOut <= `NIBBLE_IDLE;
      analogPowerDown <= 1'b1;
      clockGateOff <= 1'b0;
      lowPowerMode <= 1'b1;
    end else begin
      if (lowPower || wake == WAKE_ARMED) begin
        nibbleOut <= `NIBBLE_IDLE;
      end else if (wake == WAKE_FRAME) begin
        nibbleOut <= altPhase ? `NIBBLE_START_B
                              : `NIBBLE_START_A;
      end else begin
        nibbleOut <= videoNibble;
      end
      // registers untouched on entry to low power
      analogPowerDown <= lowPower || suspendSync[1];
      clockGateOff <= suspendSync[1];
      lowPowerMode <= lowPower;
    end
  end

endmodule
`default_nettype wire

/* hdl/sensor_serial_host.sv */
// Purpose: controller end: two-wire master steered over wishbone
// Assumes: one message sequence per go command
// Notes: scl quarter period keeps the rate at or below 100 kHz
`timescale 1ns/100ps
`default_nettype none
`include "sensor_serial_map.svh"
module sensor_serial_host
  import sensor_serial_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // link to sensor
  sensor_serial_if.host bus
);

  localparam logic [6:0] QUARTER = 7'(`SCL_QUARTER_CYCLES);

  // ********************************************
  // sequence of steps for each command
  // ********************************************
  function automatic host_step_type stepAt(input logic [3:0] k,
      input logic rd, input logic nd, input logic si);
    host_step_type s;
    logic [3:0] j;
    s = STEP_STOP;
    j = (rd && si) ? k - 4'h3 : k;
    if (!rd || (si && k < 4'h3)) begin
      // write, or index prefix of a read
      case (k)
        4'h0: s = STEP_START;
        4'h1: s = STEP_ADDR_WR;
        4'h2: s = STEP_INDEX;
        4'h3: s = nd ? STEP_STOP : STEP_DATA;
        default: s = STEP_STOP;
      endcase
    end else begin
      // start or restart, read index byte, data byte with nack
      case (j)
        4'h0: s = STEP_START;
        4'h1: s = STEP_ADDR_RD;
        4'h2: s = STEP_RECV_ACK;
        4'h3: s = STEP_RECV_NACK;
        default: s = STEP_STOP;
      endcase
    end
    return s;
  endfunction

  // ********************************************
  // wishbone slave and controller registers
  // ********************************************
  logic wbWrite;
  logic goReq;
  logic [7:0] txData;
  logic [7:0] idxByte;
  logic busy;
  logic nack;
  logic [7:0] rxData;
  logic [7:0] rxIndex;

  assign wbWrite = cyc_i && stb_i && we_i && ack_o;
  assign goReq = wbWrite && adr_i == `HOST_CMD_OFFSET && sel_i[0] &&
                 dat_i[`CMD_GO_BIT] && !busy;

  // ack one cycle after request, dropped the next
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= 32'h0000_0000;
      if (cyc_i && stb_i && !we_i && !ack_o) begin
        unique case (adr_i)
          `HOST_DATA_OFFSET: begin
            dat_o[`DATA_TX_LSB +: 8] <= txData;
            dat_o[`DATA_INDEX_LSB +: 8] <= idxByte;
          end
          `HOST_STATUS_OFFSET: begin
            dat_o[`STAT_BUSY_BIT] <= busy;
            dat_o[`STAT_NACK_BIT] <= nack;
            dat_o[`STAT_RXDATA_LSB +: 8] <= rxData;
            dat_o[`STAT_RXINDEX_LSB +: 8] <= rxIndex;
          end
          default: ;
        endcase
      end
    end
  end

  // data register, byte lanes honoured
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txData <= 8'h00;
      idxByte <= 8'h00;
    end else if (wbWrite && adr_i == `HOST_DATA_OFFSET) begin
      if (sel_i[0]) begin
        txData <= dat_i[`DATA_TX_LSB +: 8];
      end
      if (sel_i[1]) begin
        idxByte <= dat_i[`DATA_INDEX_LSB +: 8];
      end
    end
  end

  // ********************************************
  // bit engine
  // ********************************************
  logic [1:0] sdaSync;
  logic cmdRead;
  logic cmdNoData;
  logic cmdSetIdx;
  logic abort;
  logic [3:0] stepNum;
  logic [3:0] bitIdx;
  logic [1:0] phase;
  logic [6:0] quarterCnt;
  logic [7:0] rxShift;
  logic scl;
  logic sdaOe;
  logic sdaOut;
  host_step_type step;
  logic [7:0] curByte;
  logic sending;

  assign step = abort ? STEP_STOP
                      : stepAt(stepNum, cmdRead, cmdNoData, cmdSetIdx);
  assign sending = step == STEP_ADDR_WR || step == STEP_ADDR_RD ||
                   step == STEP_INDEX || step == STEP_DATA;

  // byte sent in the current step
  always_comb begin
    unique case (step)
      STEP_ADDR_WR: curByte = `SLAVE_ADDR_WRITE;
      STEP_ADDR_RD: curByte = `SLAVE_ADDR_READ;
      STEP_INDEX: curByte = idxByte;
      STEP_DATA: curByte = txData;
      default: curByte = 8'h00;
    endcase
  end

  // sda sampled through two flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sdaSync <= 2'h3;
    end else begin
      sdaSync <= {sdaSync[0], bus.sdaLine};
    end
  end

  // quarter-period ticks set the scl rate
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmdRead <= 1'b0;
      cmdNoData <= 1'b0;
      cmdSetIdx <= 1'b0;
      busy <= 1'b0;
      nack <= 1'b0;
      abort <= 1'b0;
      stepNum <= 4'h0;
      bitIdx <= 4'h0;
      phase <= 2'h0;
      quarterCnt <= 7'h00;
      rxShift <= 8'h00;
      rxData <= 8'h00;
      rxIndex <= 8'h00;
      scl <= 1'b1;
      sdaOe <= 1'b0;
    end else if (goReq) begin
      cmdRead <= dat_i[`CMD_READ_BIT];
      cmdNoData <= dat_i[`CMD_NODATA_BIT];
      cmdSetIdx <= dat_i[`CMD_SETIDX_BIT];
      busy <= 1'b1;
      nack <= 1'b0;
      abort <= 1'b0;
      stepNum <= 4'h0;
      bitIdx <= 4'h0;
      phase <= 2'h0;
      quarterCnt <= 7'h00;
    end else if (busy) begin
      quarterCnt <= (quarterCnt == QUARTER - 7'h01) ? 7'h00
                                                    : quarterCnt + 7'h01;
      if (quarterCnt == QUARTER - 7'h01) begin
        phase <= phase + 2'h1;
        unique case (phase)
          2'h0: scl <= 1'b0;
          2'h1: begin
            // data and ack bits change only while scl is low
            if (step == STEP_START) begin
              sdaOe <= 1'b0;
            end else if (step == STEP_STOP) begin
              sdaOe <= 1'b1;
            end else if (sending) begin
              sdaOe <= (bitIdx < 4'h8) && !curByte[3'(4'h7 - bitIdx)];
            end else begin
              sdaOe <= bitIdx == 4'h8 && step == STEP_RECV_ACK;
            end
          end
          2'h2: scl <= 1'b1;
          2'h3: begin
            if (step == STEP_START) begin
              sdaOe <= 1'b1; // sda falls, scl high
              stepNum <= stepNum + 4'h1;
            end else if (step == STEP_STOP) begin
              sdaOe <= 1'b0; // sda rises, scl high
              busy <= 1'b0;
            end else if (bitIdx == 4'h8) begin
              bitIdx <= 4'h0;
              stepNum <= stepNum + 4'h1;
              if (sending && sdaSync[1]) begin
                nack <= 1'b1; // no slave ack: end message
                abort <= 1'b1;
              end
              if (step == STEP_RECV_ACK) begin
                rxIndex <= rxShift;
              end
              if (step == STEP_RECV_NACK) begin
                rxData <= rxShift;
              end
            end else begin
              rxShift <= {rxShift[6:0], sdaSync[1]};
              bitIdx <= bitIdx + 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // open-drain output only ever pulls low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  assign bus.scl = scl;
  assign bus.hostSdaOe = sdaOe;
  assign bus.hostSdaOut = sdaOut;

endmodule
`default_nettype wire

/* dv/sensor_serial_monitor.sv */
// Purpose: wire checks on the two-wire control link
// Assumes: both link ends are design modules
// Notes: takes interface signals as plain inputs
`timescale 1ns/100ps
`default_nettype none
module sensor_serial_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link signals
  input wire logic scl,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic sdaLine
);
  logic sclQ;
  logic [7:0] sclCnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // *****
  // scl phase length counter
  // *****
  // previous scl level
  always_ff @(posedge sys_clk)
    sclQ <= scl;
  // cycles since scl last moved, saturating
  always_ff @(posedge sys_clk)
    if (rst)
      sclCnt <= 8'hFF;
    else if (scl != sclQ)
      sclCnt <= 8'h01;
    else if (sclCnt != 8'hFF)
      sclCnt <= sclCnt + 8'h01;
  // *****
  // link conditions
  // *****
  sequence s_start;
    scl && $past(scl) && $fell(sdaLine);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sdaLine);
  endsequence
  // each half of scl lasts at least 190 sys_clk cycles
  property p_scl_rate;
    $changed(scl) |-> sclCnt >= 8'hBE;
  endproperty
  a_scl_rate: assert property (p_scl_rate)
    else $error("scl phase too short");
  // device moves sda only while scl is low
  property p_dev_low_only;
    $changed(devSdaOe) |-> !scl && !$past(scl);
  endproperty
  a_dev_low_only: assert property (p_dev_low_only)
    else $error("device moved sda while scl high");
  // a device pull holds for 8 cycles with scl low
  property p_ack_hold;
    $rose(devSdaOe) |-> (devSdaOe && !scl) [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("device pull dropped early");
  // start keeps sda low with scl high
  property p_start_hold;
    s_start |-> (scl && !sdaLine) [*8];
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start condition not held");
  // stop leaves the bus idle high
  property p_stop_hold;
    s_stop |-> ##1 (scl && sdaLine) [*8];
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop condition not held");
  // device is silent when a message opens
  property p_start_quiet;
    s_start |-> !devSdaOe && !$past(devSdaOe);
  endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("device pulls sda at start");
  // open-drain data values are always zero
  property p_open_drain;
    !hostSdaOut && !devSdaOut;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("sda data value not zero");
  // reset leaves the wire released and scl high
  property p_reset_idle;
    disable iff (1'b0) rst |=> !devSdaOe && !hostSdaOe && scl;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("link not idle after reset");
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: self-checking bench, host and device joined
// Assumes: wishbone answers one cycle after request
// Notes: about 80k cycles of link traffic
`timescale 1ns/100ps
`default_nettype none
`include "sensor_serial_map.svh"
module tb
  import sensor_serial_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst, cyc, stb, writeEn, ack, suspendPin, frameStrobe;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, st, q;
  logic [4:0] videoNibble, nibbleOut, n1, n2;
  logic analogPowerDown, clockGateOff, lowPowerMode;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  sensor_serial_if link();
  sensor_serial_host u_sensor_serial_host (.sys_clk(sys_clk), .rst(rst),
    .cyc_i(cyc), .stb_i(stb), .we_i(writeEn), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .bus(link));
  sensor_serial_device u_sensor_serial_device (.sys_clk(sys_clk),
    .rst(rst), .bus(link), .suspendPin(suspendPin),
    .frameStrobe(frameStrobe), .videoNibble(videoNibble),
    .nibbleOut(nibbleOut), .analogPowerDown(analogPowerDown),
    .clockGateOff(clockGateOff), .lowPowerMode(lowPowerMode));
  sensor_serial_monitor u_sensor_serial_monitor (.sys_clk(sys_clk),
    .rst(rst), .scl(link.scl), .hostSdaOut(link.hostSdaOut),
    .hostSdaOe(link.hostSdaOe), .devSdaOut(link.devSdaOut),
    .devSdaOe(link.devSdaOe), .sdaLine(link.sdaLine));
  // *****
  // tasks
  // *****
  task end_of_test;
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // compare and count
  task chk(input string name, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  // one classic wishbone cycle
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    writeEn <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // load data, issue command, wait until idle
  task automatic msg(input logic [3:0] c, input logic [7:0] i,
    input logic [7:0] d);
    wb(1'b1, `HOST_DATA_OFFSET, {16'h0000, i, d});
    wb(1'b1, `HOST_CMD_OFFSET, {28'h0000000, c});
    do begin
      wb(1'b0, `HOST_STATUS_OFFSET, 32'h00000000);
      st = q;
    end while (st[0] !== 1'b0);
    chk("nack", 8'h00, {7'h00, st[1]});
  endtask
  // one-cycle frame start pulse
  task strobe;
    @(posedge sys_clk);
    frameStrobe <= 1'b1;
    @(posedge sys_clk);
    frameStrobe <= 1'b0;
  endtask
  // *****
  // clock and watchdog
  // *****
  initial forever #12.5 sys_clk = ~sys_clk;
  // cut a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 95000) begin
      num_errors++;
      end_of_test();
    end
  end
  // *****
  // main sequence
  // *****
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    writeEn = 1'b0;
    adr = 4'h0;
    sel = 4'h0;
    wdat = 32'h00000000;
    suspendPin = 1'b0;
    frameStrobe = 1'b0;
    videoNibble = 5'h0A;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("nib", 8'h1F, nibbleOut); // all ones at power-up
    chk("lowPow", 8'h01, lowPowerMode);
    chk("apd", 8'h01, analogPowerDown);
    msg(4'h1, 8'h20, 8'h55); // write index 32
    msg(4'h3, 8'h00, 8'h00); // plain read
    chk("rxIdx", 8'h20, st[23:16]); // index kept
    chk("rxDat", 8'h55, st[15:8]); // stored byte
    msg(4'h1, 8'h90, 8'h00); // wake, auto-increment
    chk("lowPow", 8'h00, lowPowerMode);
    chk("apd", 8'h00, analogPowerDown);
    chk("nib", 8'h1F, nibbleOut); // no video yet
    strobe();
    repeat (3) @(posedge sys_clk);
    n1 = nibbleOut;
    @(posedge sys_clk);
    n2 = nibbleOut;
    chk("nibPair", 8'h01, {7'h00, (n1 ^ n2) === 5'h0F &&
      (n1 === 5'h09 || n1 === 5'h06)}); // start-up frame
    strobe();
    repeat (3) @(posedge sys_clk);
    chk("video", 8'h0A, nibbleOut); // video after one frame
    suspendPin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("gate", 8'h01, clockGateOff);
    chk("apd", 8'h01, analogPowerDown);
    suspendPin <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk("gate", 8'h00, clockGateOff);
    msg(4'h3, 8'h00, 8'h00); // read after increment
    chk("rxIdx", 8'h91, st[23:16]); // one past last
    chk("rxDat", 8'h00, st[15:8]); // register 17 default
    msg(4'h1, 8'h10, 8'h04); // soft reset
    chk("lowPow", 8'h01, lowPowerMode);
    chk("nib", 8'h1F, nibbleOut);
    msg(4'hB, 8'h20, 8'h00); // index-only write then read
    chk("rxIdx", 8'h20, st[23:16]);
    chk("rxDat", 8'h00, st[15:8]); // default restored
    end_of_test();
  end
endmodule
`default_nettype wire
